// [smpwm_load.sv]
// Load model that measures pulse widths, periods and rising edges of every output.
`timescale 1ns/100ps
module smpwm_load
    import smpwm_pkg::*;
(
    input wire logic clk,
    input wire logic [NUM_OUT-1:0] pwm_out,
    output int hi_len [NUM_OUT],
    output int per_len [NUM_OUT],
    output int rises [NUM_OUT]
);
    // ****************
    // Measurement.
    // ****************
    int hc [NUM_OUT] = '{default: 0};
    int pc [NUM_OUT] = '{default: 0};
    logic [NUM_OUT-1:0] prev = '0;
    initial begin
        rises = '{default: 0};
        hi_len = '{default: 0};
        per_len = '{default: 0};
    end
    always @(posedge clk) begin
        for (int k = 0; k < NUM_OUT; k++) begin
            if (!pwm_out[k] && prev[k]) hi_len[k] = hc[k];
            hc[k] = pwm_out[k] ? hc[k] + 1 : 0;
            if (pwm_out[k] && !prev[k]) begin
                per_len[k] = pc[k];
                pc[k] = 0;
                rises[k] = rises[k] + 1;
            end
            pc[k] = pc[k] + 1;
        end
        prev = pwm_out;
    end
endmodule : smpwm_load

// [smpwm_monitor.sv]
// Checker of bus handshakes and output levels of the PWM unit.
`timescale 1ns/100ps
module smpwm_monitor
    import smpwm_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire smpwm_axi_req_s axi_req,
    input wire smpwm_axi_rsp_s axi_rsp,
    input wire logic [NUM_OUT-1:0] pwm_out
);
    // ****************
    // Shadow of output enables and PWM mode.
    // ****************
    logic [ADDR_W-1:0] wa_r;
    logic [31:0] wd_r;
    logic [3:0] ws_r;
    logic bv_r;
    logic [NUM_OUT-1:0] oen_r;
    logic pwm_r;
    always_ff @(posedge clk) begin
        if (srst) begin
            wa_r <= '0;
            wd_r <= '0;
            ws_r <= '0;
            bv_r <= 1'b0;
            oen_r <= '0;
            pwm_r <= 1'b0;
        end else begin
            bv_r <= axi_rsp.bvalid;
            if (axi_req.awvalid && axi_rsp.awready) wa_r <= axi_req.awaddr;
            if (axi_req.wvalid && axi_rsp.wready) begin
                wd_r <= axi_req.wdata;
                ws_r <= axi_req.wstrb;
            end
            if (axi_rsp.bvalid && !bv_r && axi_rsp.bresp == RESP_OKAY) begin
                if (wa_r == OFS_PWM_CTL && ws_r[1]) oen_r <= wd_r[PCTL_OEN_LSB +: NUM_OUT];
                if (wa_r == OFS_CTRL && ws_r[0]) pwm_r <= wd_r[CTRL_PWM_BIT];
            end
        end
    end
    // ****************
    // Assertions.
    // ****************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    a_bvalid_hold: assert property (
        axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
        else $error("Write response changed before it was taken.");
    a_rvalid_hold: assert property (
        axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
        else $error("Read data changed before it was taken.");
    a_read_next: assert property (
        axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid && !axi_rsp.arready)
        else $error("Read answer missing one cycle after the address.");
    a_write_answer: assert property (
        axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
        |-> ##[1:3] axi_rsp.bvalid) else $error("Write answer missing.");
    a_bad_read: assert property (
        axi_req.arvalid && axi_rsp.arready && (axi_req.araddr >= OFS_END ||
        axi_req.araddr[1:0] != 2'h0) |=> axi_rsp.rresp == RESP_SLVERR && axi_rsp.rdata == 32'h0)
        else $error("Bad read address not refused.");
    a_reset_idle: assert property (disable iff (1'b0)
        srst |=> !axi_rsp.bvalid && !axi_rsp.rvalid && pwm_out == '0)
        else $error("Unit not idle after reset.");
    a_const_low: assert property (
        (pwm_out & ~oen_r & ~$past(oen_r)) == '0) else $error("Disabled output went high.");
    a_timer_quiet: assert property (
        !pwm_r && !$past(pwm_r) |-> pwm_out == '0) else $error("Output high in timer mode.");
    c_write: cover property (axi_rsp.bvalid && axi_req.bready);
    c_bad_read: cover property (axi_rsp.rvalid && axi_rsp.rresp == RESP_SLVERR);
    c_out_rise: cover property ($rose(pwm_out[0]));
endmodule : smpwm_monitor

bind smpwm_unit smpwm_monitor u_smpwm_monitor (.clk(clk), .srst(srst), .axi_req(axi_req),
    .axi_rsp(axi_rsp), .pwm_out(pwm_out));

// [smpwm_pkg.sv]
// Package with register map, field layout and bus carriers of the PWM unit.
package smpwm_pkg;

    // ****************************************************************
    // Sizes and register offsets.
    // ****************************************************************
    localparam int ADDR_W = 8;
    localparam int NUM_MATCH = 7;
    localparam int NUM_OUT = 6;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_PRESCALE = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_PRECOUNT = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_MATCH_CTL = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_PWM_CTL = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_RELEASE = 8'h1c;
    localparam logic [ADDR_W-1:0] OFS_MATCH0 = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_END = 8'h3c;

    // ****************************************************************
    // Field positions and reset values.
    // ****************************************************************
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_CLR_BIT = 1;
    localparam int CTRL_PWM_BIT = 3;
    localparam int MCTL_IRQ_BIT = 0;
    localparam int MCTL_RST_BIT = 1;
    localparam int MCTL_STOP_BIT = 2;
    localparam int MCTL_STRIDE = 3;
    localparam int PCTL_DBL_LSB = 2;
    localparam int PCTL_OEN_LSB = 9;
    localparam logic [31:0] RST_VAL = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ****************************************************************
    // Bus carriers.
    // ****************************************************************
    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } smpwm_axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } smpwm_axi_rsp_s;

endpackage : smpwm_pkg

// [smpwm_unit.sv]
// Seven-match PWM unit with prescaled counter and register slave.
//
// Added by the designer: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps

module smpwm_unit
    import smpwm_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire smpwm_axi_req_s axi_req,
    output smpwm_axi_rsp_s axi_rsp,
    output logic [NUM_OUT-1:0] pwm_out
);

    // ****************************************************************
    // Declarations.
    // ****************************************************************
    logic cnt_en_r;
    logic cnt_clr_r;
    logic pwm_en_r;
    logic [NUM_MATCH-1:0] flags_r;
    logic [31:0] count_r;
    logic [31:0] prescale_r;
    logic [31:0] precount_r;
    logic [MCTL_STRIDE*NUM_MATCH-1:0] mctl_r;
    logic [NUM_OUT:2] dbl_r;
    logic [NUM_OUT-1:0] oen_r;
    logic [NUM_MATCH-1:0] release_r;
    logic [31:0] match_sh_r [NUM_MATCH];
    logic [31:0] match_act_r [NUM_MATCH];
    logic [NUM_OUT-1:0] level_r;
    logic aw_full_r;
    logic w_full_r;
    logic [ADDR_W-1:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic tick;
    logic [NUM_MATCH-1:0] hit;
    logic [NUM_MATCH-1:0] stop_hit;
    logic [NUM_MATCH-1:0] rst_bits;
    logic cyc_start;
    logic wr_fire;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_ok;
    logic [31:0] rd_val;
    logic rd_ok;
    logic [31:0] mctl_mrg;
    logic [31:0] pctl_mrg;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = data[8*b +: 8];
            end
        end
        return res;
    endfunction : merge

    // ****************************************************************
    // Write channel: address and data are held until both are in.
    // ****************************************************************
    assign axi_rsp.awready = !aw_full_r;
    assign axi_rsp.wready = !w_full_r;
    assign axi_rsp.bvalid = bvalid_r;
    assign axi_rsp.bresp = bresp_r;
    assign wr_fire = aw_full_r && w_full_r && !bvalid_r;
    assign wr_addr = aw_addr_r;
    assign wr_strb = w_strb_r;
    assign wr_data = w_data_r;
    assign wr_ok = (wr_addr < OFS_END) && (wr_addr[1:0] == 2'h0) && (wr_addr != OFS_PRECOUNT);

    always_ff @(posedge clk) begin
        if (srst) begin
            aw_full_r <= 1'b0;
            aw_addr_r <= '0;
        end else if (!aw_full_r && axi_req.awvalid) begin
            aw_full_r <= 1'b1;
            aw_addr_r <= axi_req.awaddr;
        end else if (wr_fire) begin
            aw_full_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            w_full_r <= 1'b0;
            w_data_r <= RST_VAL;
            w_strb_r <= 4'h0;
        end else if (!w_full_r && axi_req.wvalid) begin
            w_full_r <= 1'b1;
            w_data_r <= axi_req.wdata;
            w_strb_r <= axi_req.wstrb;
        end else if (wr_fire) begin
            w_full_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (axi_req.bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // ****************************************************************
    // Read channel: one read at a time, data registered.
    // ****************************************************************
    assign axi_rsp.arready = !rvalid_r;
    assign axi_rsp.rvalid = rvalid_r;
    assign axi_rsp.rdata = rdata_r;
    assign axi_rsp.rresp = rresp_r;

    always_comb begin
        rd_val = RST_VAL;
        rd_ok = axi_req.araddr[1:0] == 2'h0;
        case (axi_req.araddr)
            OFS_CTRL: begin
                rd_val[CTRL_EN_BIT] = cnt_en_r;
                rd_val[CTRL_CLR_BIT] = cnt_clr_r;
                rd_val[CTRL_PWM_BIT] = pwm_en_r;
            end
            OFS_FLAGS: rd_val[NUM_MATCH-1:0] = flags_r;
            OFS_COUNT: rd_val = count_r;
            OFS_PRESCALE: rd_val = prescale_r;
            OFS_PRECOUNT: rd_val = precount_r;
            OFS_MATCH_CTL: rd_val[MCTL_STRIDE*NUM_MATCH-1:0] = mctl_r;
            OFS_PWM_CTL: begin
                rd_val[NUM_OUT:PCTL_DBL_LSB] = dbl_r;
                rd_val[PCTL_OEN_LSB +: NUM_OUT] = oen_r;
            end
            OFS_RELEASE: rd_val[NUM_MATCH-1:0] = release_r;
            default: begin
                if (axi_req.araddr >= OFS_MATCH0 && axi_req.araddr < OFS_END) begin
                    rd_val = match_sh_r[3'((axi_req.araddr - OFS_MATCH0) >> 2)];
                end else begin
                    rd_ok = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rvalid_r <= 1'b0;
            rdata_r <= RST_VAL;
            rresp_r <= RESP_OKAY;
        end else if (!rvalid_r && axi_req.arvalid) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_ok ? rd_val : RST_VAL;
            rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (axi_req.rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // ****************************************************************
    // Control register; a stopping match clears the enable.
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_en_r <= 1'b0;
            cnt_clr_r <= 1'b0;
            pwm_en_r <= 1'b0;
        end else if (wr_fire && wr_addr == OFS_CTRL && wr_strb[0]) begin
            cnt_en_r <= wr_data[CTRL_EN_BIT];
            cnt_clr_r <= wr_data[CTRL_CLR_BIT];
            pwm_en_r <= wr_data[CTRL_PWM_BIT];
        end else if (|stop_hit) begin
            cnt_en_r <= 1'b0;
        end
    end

    // ****************************************************************
    // Configuration registers.
    // ****************************************************************
    assign mctl_mrg = merge({11'h0, mctl_r}, wr_data, wr_strb);
    assign pctl_mrg = merge({17'h0, oen_r, 2'h0, dbl_r, 2'h0}, wr_data, wr_strb);

    always_ff @(posedge clk) begin
        if (srst) begin
            prescale_r <= RST_VAL;
        end else if (wr_fire && wr_addr == OFS_PRESCALE) begin
            prescale_r <= merge(prescale_r, wr_data, wr_strb);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            mctl_r <= '0;
        end else if (wr_fire && wr_addr == OFS_MATCH_CTL) begin
            mctl_r <= mctl_mrg[MCTL_STRIDE*NUM_MATCH-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            dbl_r <= '0;
            oen_r <= '0;
        end else if (wr_fire && wr_addr == OFS_PWM_CTL) begin
            dbl_r <= pctl_mrg[NUM_OUT:PCTL_DBL_LSB];
            oen_r <= pctl_mrg[PCTL_OEN_LSB +: NUM_OUT];
        end
    end

    // ****************************************************************
    // Prescaler and counter.
    // ****************************************************************
    assign tick = cnt_en_r && !cnt_clr_r && (precount_r == prescale_r);

    always_ff @(posedge clk) begin
        if (srst || cnt_clr_r) begin
            precount_r <= RST_VAL;
        end else if (cnt_en_r) begin
            precount_r <= tick ? RST_VAL : precount_r + 32'h1;
        end
    end

    assign cyc_start = |(hit & rst_bits);

    always_ff @(posedge clk) begin
        if (srst || cnt_clr_r) begin
            count_r <= RST_VAL;
        end else if (wr_fire && wr_addr == OFS_COUNT) begin
            count_r <= merge(count_r, wr_data, wr_strb);
        end else if (tick) begin
            count_r <= cyc_start ? RST_VAL : count_r + 32'h1;
        end
    end

    // ****************************************************************
    // Match compare, once per tick, per match register.
    // ****************************************************************
    generate
        for (genvar i = 0; i < NUM_MATCH; i++) begin : g_match
            assign hit[i] = tick && (count_r == match_act_r[i]);
            assign stop_hit[i] = hit[i] && mctl_r[MCTL_STRIDE*i + MCTL_STOP_BIT];
            if (i == 0) begin : g_cyc
                assign rst_bits[i] = mctl_r[MCTL_RST_BIT] || pwm_en_r;
            end else begin : g_oth
                assign rst_bits[i] = mctl_r[MCTL_STRIDE*i + MCTL_RST_BIT];
            end

            always_ff @(posedge clk) begin
                if (srst) begin
                    match_sh_r[i] <= RST_VAL;
                end else if (wr_fire && wr_addr == OFS_MATCH0 + 8'(4*i)) begin
                    match_sh_r[i] <= merge(match_sh_r[i], wr_data, wr_strb);
                end
            end

            always_ff @(posedge clk) begin
                if (srst) begin
                    match_act_r[i] <= RST_VAL;
                end else if (!pwm_en_r) begin
                    match_act_r[i] <= match_sh_r[i];
                end else if (tick && hit[0] && release_r[i]) begin
                    match_act_r[i] <= match_sh_r[i];
                end
            end

            always_ff @(posedge clk) begin
                if (srst) begin
                    release_r[i] <= 1'b0;
                end else if (wr_fire && wr_addr == OFS_RELEASE && wr_strb[0] && wr_data[i]) begin
                    release_r[i] <= 1'b1;
                end else if (pwm_en_r && hit[0]) begin
                    release_r[i] <= 1'b0;
                end
            end

            always_ff @(posedge clk) begin
                if (srst) begin
                    flags_r[i] <= 1'b0;
                end else if (hit[i] && mctl_r[MCTL_STRIDE*i + MCTL_IRQ_BIT]) begin
                    flags_r[i] <= 1'b1;
                end else if (wr_fire && wr_addr == OFS_FLAGS && wr_strb[0] && wr_data[i]) begin
                    flags_r[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Output edges; output n uses match n, and n-1 when double-edged.
    // ****************************************************************
    generate
        for (genvar n = 1; n <= NUM_OUT; n++) begin : g_out
            logic set_ev;
            if (n == 1) begin : g_single
                assign set_ev = hit[0];
            end else begin : g_sel
                assign set_ev = dbl_r[n] ? hit[n-1] : hit[0];
            end

            always_ff @(posedge clk) begin
                if (srst || !pwm_en_r || !oen_r[n-1]) begin
                    level_r[n-1] <= 1'b0;
                end else if (hit[n]) begin
                    level_r[n-1] <= 1'b0;
                end else if (set_ev) begin
                    level_r[n-1] <= 1'b1;
                end
            end
        end
    endgenerate

    assign pwm_out = level_r;

endmodule : smpwm_unit

// [test_smpwm_unit.sv]
// Self-checking testbench of the PWM unit with a register model.
`timescale 1ns/100ps
module test_smpwm_unit
    import smpwm_pkg::*;
;
    // ****************
    // Signals and instances.
    // ****************
    logic clk = 1'b0;
    logic srst = 1'b1;
    smpwm_axi_req_s req = '0;
    smpwm_axi_rsp_s rsp;
    logic [NUM_OUT-1:0] pwm_out;
    int hi_len [NUM_OUT];
    int per_len [NUM_OUT];
    int rises [NUM_OUT];
    int r0 [NUM_OUT];
    int exph [NUM_OUT];
    int n_mismatch = 0;
    int cmp_count = 0;
    int m [NUM_MATCH] = '{19, 4, 9, 15, 12, 30, 7};
    int ps = 1;
    logic [31:0] seed = 32'h0000_0057;
    logic [31:0] mdl [16];
    logic [31:0] rdv;
    logic [1:0] rsv;
    smpwm_unit u_smpwm_unit (.clk(clk), .srst(srst), .axi_req(req), .axi_rsp(rsp),
        .pwm_out(pwm_out));
    smpwm_load u_smpwm_load (.clk(clk), .pwm_out(pwm_out), .hi_len(hi_len),
        .per_len(per_len), .rises(rises));
    initial begin
        forever #2.5 clk = ~clk;
    end
    // ****************
    // Helpers and bus tasks.
    // ****************
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    function automatic int sgl(int w);
        return (w + 1) * (ps + 1);
    endfunction : sgl
    function automatic int dbl(int r, int f);
        return ((f - r + m[0] + 1) % (m[0] + 1)) * (ps + 1);
    endfunction : dbl
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw;
        logic w;
        aw = 1'b0;
        w = 1'b0;
        @(posedge clk);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.bready <= 1'b1;
        do begin
            @(posedge clk);
            if (req.awvalid && rsp.awready) begin
                aw = 1'b1;
                req.awvalid <= 1'b0;
            end
            if (req.wvalid && rsp.wready) begin
                w = 1'b1;
                req.wvalid <= 1'b0;
            end
        end while (!(aw && w));
        do @(posedge clk); while (rsp.bvalid !== 1'b1);
        req.bready <= 1'b0;
        chk(rsp.bresp, er);
        if (er == RESP_OKAY && a != OFS_FLAGS && a != OFS_RELEASE) mdl[a[5:2]] = d;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        do @(posedge clk); while (rsp.arready !== 1'b1);
        req.arvalid <= 1'b0;
        do @(posedge clk); while (rsp.rvalid !== 1'b1);
        req.rready <= 1'b0;
        rdv = rsp.rdata;
        rsv = rsp.rresp;
    endtask : rd
    task automatic rd_chk(input logic [7:0] a);
        logic bad;
        bad = a >= OFS_END || a[1:0] != 2'h0;
        rd(a);
        chk(rdv, bad ? 32'h0 : mdl[a[5:2]]);
        chk(rsv, bad ? RESP_SLVERR : RESP_OKAY);
    endtask : rd_chk
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test
    // ****************
    // Scenarios.
    // ****************
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        finish_test();
    end
    initial begin
        foreach (mdl[i]) mdl[i] = 32'h0;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        for (int a = 0; a < 64; a += 4) rd_chk(8'(a));
        rd_chk(8'h21);
        wr(OFS_PRECOUNT, 32'h1, RESP_SLVERR);
        for (int i = 0; i < 8; i++) begin
            wr(OFS_MATCH0 + 8'(4 * i), xs(), (i < 7) ? RESP_OKAY : RESP_SLVERR);
            rd_chk(OFS_MATCH0 + 8'(4 * i));
        end
        wr(OFS_PRESCALE, xs(), RESP_OKAY);
        rd_chk(OFS_PRESCALE);
        wr(OFS_PRESCALE, 32'(ps), RESP_OKAY);
        for (int i = 0; i < NUM_MATCH; i++) wr(OFS_MATCH0 + 8'(4 * i), 32'(m[i]), RESP_OKAY);
        wr(OFS_PWM_CTL, 32'h0000_7614, RESP_OKAY);
        wr(OFS_RELEASE, 32'h0000_007f, RESP_OKAY);
        wr(OFS_CTRL, 32'h0000_0009, RESP_OKAY);
        repeat (120) @(posedge clk);
        r0 = rises;
        repeat (120) @(posedge clk);
        exph = '{sgl(m[1]), dbl(m[1], m[2]), 0, dbl(m[3], m[4]), 0, sgl(m[6])};
        for (int k = 0; k < NUM_OUT; k++) begin
            if (exph[k] != 0) chk(hi_len[k], exph[k]);
            if (exph[k] != 0) chk(per_len[k], (m[0] + 1) * (ps + 1));
        end
        chk(rises[2] - r0[2], 0);
        chk(rises[4] - r0[4], 0);
        chk(pwm_out[4], 1'b1);
        wr(OFS_MATCH0 + 8'h04, 32'h9, RESP_OKAY);
        repeat (120) @(posedge clk);
        chk(hi_len[0], sgl(m[1]));
        m[1] = 9;
        wr(OFS_RELEASE, 32'h0000_0002, RESP_OKAY);
        repeat (120) @(posedge clk);
        chk(hi_len[0], sgl(m[1]));
        wr(OFS_MATCH_CTL, 32'h0014_0000, RESP_OKAY);
        repeat (60) @(posedge clk);
        mdl[0][CTRL_EN_BIT] = 1'b0;
        rd_chk(OFS_CTRL);
        rd(OFS_FLAGS);
        chk(rdv, 32'h0000_0040);
        wr(OFS_FLAGS, 32'h0000_0040, RESP_OKAY);
        rd(OFS_FLAGS);
        chk(rdv, 32'h0);
        wr(OFS_MATCH_CTL, 32'h0000_0400, RESP_OKAY);
        wr(OFS_CTRL, 32'h0000_0001, RESP_OKAY);
        for (int i = 0; i < 10; i++) begin
            repeat (10) @(posedge clk);
            chk(pwm_out, 6'h00);
        end
        rd(OFS_COUNT);
        chk(rdv <= 32'h0000_000f, 1'b1);
        wr(OFS_CTRL, 32'h0000_0003, RESP_OKAY);
        rd(OFS_COUNT);
        chk(rdv, 32'h0);
        wr(OFS_CTRL, 32'h0000_0000, RESP_OKAY);
        wr(OFS_COUNT, 32'h0000_0005, RESP_OKAY);
        rd_chk(OFS_COUNT);
        rd_chk(OFS_PRECOUNT);
        finish_test();
    end
endmodule : test_smpwm_unit
